// ### core/pasic_pkg.sv
// Constants, field layout and state codes for the PHY management registers.
// Assumes a single 10 MHz clock and MDIO frames with MDC well below that rate.
package pasic_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [4:0] REG_AUX_CTRL = 5'h10;
    localparam logic [4:0] REG_AUX_STAT = 5'h11;
    localparam logic [4:0] REG_INT_EN = 5'h12;
    localparam logic [4:0] REG_DP_CTRL = 5'h13;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int AUX_BYPASS_ALIGN = 7;
    localparam logic [15:0] AUX_CTRL_MASK = 16'h00a6;
    localparam logic [15:0] INT_EN_MASK = 16'h007f;
    localparam logic [15:0] DP_CTRL_MASK = 16'h2be3;
    localparam int STAT_OVERRUN = 11;
    localparam int STAT_SPEED = 9;
    localparam int STAT_DUPLEX = 8;
    localparam int STAT_PAUSE = 7;
    localparam int NUM_EVENTS = 7;
    localparam int EV_ERR_FULL = 0;
    localparam int EV_PAGE = 1;
    localparam int EV_PAR_FAULT = 2;
    localparam int EV_CODE_WORD = 3;
    localparam int EV_LINK_DOWN = 4;
    localparam int EV_REM_FAULT = 5;
    localparam int EV_AN_DONE = 6;
    localparam int DP_ERR_CNT_DIS = 13;
    localparam int DP_AN_COMPLETE = 12;
    localparam int DP_RX_VPP = 11;
    localparam int DP_LOOPBACK = 9;
    localparam int DP_DC_RESTORE = 8;
    localparam int DP_NRZI = 7;
    localparam int DP_4B5B = 6;
    localparam int DP_ISOLATE = 5;
    localparam int DP_MODE_LO = 2;
    localparam int DP_MLT3_DIS = 1;
    localparam int DP_SCR_DIS = 0;

    // ------------------------------------------------------------
    // Reset values and mode codes
    // ------------------------------------------------------------
    localparam logic [15:0] DP_CTRL_RESET = 16'h0100;
    localparam logic [2:0] MODE_NEGOTIATING = 3'h0;
    localparam logic [2:0] MODE_ISOLATED = 3'h7;
    localparam logic [4:0] PHY_ADDR_ISOLATE = 5'h00;
    localparam int ERR_CNT_W = 16;

    // ------------------------------------------------------------
    // MDIO frame
    // ------------------------------------------------------------
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [3:0] HDR_LAST = 4'hc;
    localparam logic [3:0] DATA_LAST = 4'hf;
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    typedef enum logic [3:0] {
        MD_IDLE = 4'b0001,
        MD_HDR = 4'b0010,
        MD_TA = 4'b0100,
        MD_DATA = 4'b1000
    } pasic_md_state_t;

endpackage

// ### core/pasic_err_counter.sv
// Receive error counter that pulses once every full wrap of its range.
// Assumes i_count is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
module pasic_err_counter
    import pasic_pkg::*;
#(
    parameter int WIDTH = ERR_CNT_W
)
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_count,
    input wire logic i_enable,
    output logic o_wrap
);

    logic [WIDTH-1:0] count;
    wire step = i_count && i_enable;
    wire at_top = &count;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            count <= '0;
            o_wrap <= 1'b0;
        end
        else
        begin
            if (step)
                count <= count + 1'b1;
            o_wrap <= step && at_top;
        end
    end

endmodule

// ### core/pasic_regs.sv
// What this block does
// - Aux control bit 7 set bypasses receive symbol alignment.
// - Bypass plus 4B/5B bypass puts raw five-bit codes on RXER and RXD.
// - Status bit 11 sets on elastic FIFO overrun, held until read.
// - Latched flags stay set after their event until the status read.
// - Status bit 7 shows whether pause is enabled, taken live from i_pause_en.
// - Status bit 6 flags completed auto-negotiation, resets zero.
// - Status bit 5 latches on remote fault, clears on read.
// - Status bit 4 latches when link drops after up, clears on read.
// - Status bit 3 latches on received link code word.
// - Status bit 2 latches on parallel detection fault.
// - Status bit 1 latches on received page.
// - Status bit 0 latches after 64K errant packets.
// - Interrupt enable bits 6..0 gate each source, reset zero.
// - Control bit 13 stops the receive error counter.
// - Control bit 12 reads one once auto-negotiation completed.
// - Control bit 9 enables remote loopback, resets zero.
// - Control bit 8 enables DC restoration, resets one.
// - Bits 7 and 6 enable NRZI and 4B/5B, reset from straps.
// - Bit 5 or strapped address zero isolates MII and transmit.
// - Bits 4..2 report the operating mode code.
// - Bits 1 and 0 disable MLT-3 and scrambler, reset from straps.
//
// Assumes MDC and MDIO come from pins; event inputs come from the PHY core
// on the same clock. MDC must stay at or below a quarter of i_clk.
`timescale 1ns/1ps
module pasic_regs
    import pasic_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_mdc,
    input wire logic i_mdio,
    output logic o_mdio_out,
    output logic o_mdio_oe,
    input wire logic [4:0] i_strap_phy_addr,
    input wire logic i_strap_nrzi_en,
    input wire logic i_strap_4b5b_en,
    input wire logic i_strap_mlt3_dis,
    input wire logic i_strap_scr_dis,
    input wire logic i_fifo_overrun,
    input wire logic i_remote_fault,
    input wire logic i_link_up,
    input wire logic i_code_word_rx,
    input wire logic i_par_det_fault,
    input wire logic i_page_rx,
    input wire logic i_rx_error,
    input wire logic i_an_enable,
    input wire logic i_an_complete,
    input wire logic i_pause_en,
    input wire logic i_speed_100,
    input wire logic i_full_duplex,
    output logic o_bypass_align,
    output logic o_raw_5b_rx,
    output logic o_err_cnt_disable,
    output logic o_rx_vpp_sel,
    output logic o_remote_loopback,
    output logic o_dc_restore_en,
    output logic o_nrzi_en,
    output logic o_4b5b_en,
    output logic o_isolate,
    output logic [2:0] o_mode,
    output logic o_mlt3_disable,
    output logic o_scrambler_disable,
    output logic o_irq
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Set wins over clear so an event in the read cycle is not lost.
    function automatic logic [NUM_EVENTS-1:0] latch_next(
        input logic [NUM_EVENTS-1:0] q,
        input logic [NUM_EVENTS-1:0] set,
        input logic clr
    );
        latch_next = (q & ~{NUM_EVENTS{clr}}) | set;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_q;
    logic mdio_s1;
    logic mdio_s2;
    logic [8:0] strap_s1;
    logic [8:0] strap_s2;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            mdc_s1 <= 1'b0;
            mdc_s2 <= 1'b0;
            mdc_q <= 1'b0;
            mdio_s1 <= 1'b1;
            mdio_s2 <= 1'b1;
            strap_s1 <= 9'h000;
            strap_s2 <= 9'h000;
        end
        else
        begin
            mdc_s1 <= i_mdc;
            mdc_s2 <= mdc_s1;
            mdc_q <= mdc_s2;
            mdio_s1 <= i_mdio;
            mdio_s2 <= mdio_s1;
            strap_s1 <= {i_strap_phy_addr, i_strap_nrzi_en, i_strap_4b5b_en,
                         i_strap_mlt3_dis, i_strap_scr_dis};
            strap_s2 <= strap_s1;
        end
    end

    wire mdc_rise = mdc_s2 && !mdc_q;
    wire bit_in = mdio_s2;

    // ------------------------------------------------------------
    // Strap capture after reset release
    // ------------------------------------------------------------
    // Straps are taken once the synchronisers hold post-reset pin levels.
    logic [1:0] strap_cnt;
    logic [4:0] phy_addr;
    wire strap_load = (strap_cnt == STRAP_WAIT);

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            strap_cnt <= 2'h0;
            phy_addr <= 5'h00;
        end
        else
        begin
            if (strap_cnt <= STRAP_WAIT)
                strap_cnt <= strap_cnt + 2'h1;
            if (strap_load)
                phy_addr <= strap_s2[8:4];
        end
    end

    // ------------------------------------------------------------
    // MDIO frame engine
    // ------------------------------------------------------------
    pasic_md_state_t state;
    logic prev_bit;
    logic [3:0] cnt;
    logic [11:0] hdr;
    logic [15:0] shreg;
    logic is_read;
    logic mine;
    logic [4:0] reg_addr;
    logic [15:0] rdata;

    wire [12:0] hdr_full = {hdr, bit_in};
    wire [1:0] hdr_op = hdr_full[11:10];
    wire [4:0] hdr_reg = hdr_full[4:0];
    wire hdr_mapped = (hdr_reg >= REG_AUX_CTRL) && (hdr_reg <= REG_DP_CTRL);
    wire hdr_match = hdr_full[12] && (hdr_full[9:5] == phy_addr) && hdr_mapped;
    wire hdr_done = mdc_rise && (state == MD_HDR) && (cnt == HDR_LAST);
    wire rd_stb = hdr_done && hdr_match && (hdr_op == OP_READ);
    wire data_done = mdc_rise && (state == MD_DATA) && (cnt == DATA_LAST);
    wire wr_stb = data_done && mine && !is_read;
    wire [15:0] wr_data = {shreg[14:0], bit_in};
    wire rd_stat = rd_stb && (hdr_reg == REG_AUX_STAT);

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state <= MD_IDLE;
            prev_bit <= 1'b0;
            cnt <= 4'h0;
            hdr <= 12'h000;
            shreg <= 16'h0000;
            is_read <= 1'b0;
            mine <= 1'b0;
            reg_addr <= 5'h00;
            o_mdio_out <= 1'b0;
            o_mdio_oe <= 1'b0;
        end
        else if (mdc_rise)
        begin
            unique case (state)
                MD_IDLE:
                begin
                    prev_bit <= bit_in;
                    cnt <= 4'h0;
                    if (prev_bit && !bit_in)
                        state <= MD_HDR;
                end
                MD_HDR:
                begin
                    hdr <= hdr_full[11:0];
                    cnt <= cnt + 4'h1;
                    if (hdr_done)
                    begin
                        state <= MD_TA;
                        cnt <= 4'h0;
                        is_read <= (hdr_op == OP_READ);
                        mine <= hdr_match &&
                                ((hdr_op == OP_READ) || (hdr_op == OP_WRITE));
                        reg_addr <= hdr_reg;
                        shreg <= rdata;
                    end
                end
                MD_TA:
                begin
                    cnt <= cnt + 4'h1;
                    if (cnt == 4'h0)
                    begin
                        o_mdio_oe <= mine && is_read;
                        o_mdio_out <= 1'b0;
                    end
                    else
                    begin
                        state <= MD_DATA;
                        cnt <= 4'h0;
                        o_mdio_out <= shreg[15];
                    end
                end
                MD_DATA:
                begin
                    cnt <= cnt + 4'h1;
                    if (is_read)
                    begin
                        shreg <= {shreg[14:0], 1'b0};
                        o_mdio_out <= shreg[14];
                    end
                    else
                        shreg <= wr_data;
                    if (data_done)
                    begin
                        state <= MD_IDLE;
                        prev_bit <= 1'b0;
                        o_mdio_oe <= 1'b0;
                        o_mdio_out <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Reserved bits are not stored; software must write them as zero anyway.
    logic [15:0] aux_ctrl;
    logic [15:0] int_en;
    logic [15:0] dp_ctrl;
    wire wr_aux = wr_stb && (reg_addr == REG_AUX_CTRL);
    wire wr_int = wr_stb && (reg_addr == REG_INT_EN);
    wire wr_dp = wr_stb && (reg_addr == REG_DP_CTRL);
    wire [3:0] straps = strap_s2[3:0];

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            aux_ctrl <= 16'h0000;
            int_en <= 16'h0000;
            dp_ctrl <= DP_CTRL_RESET;
        end
        else
        begin
            if (wr_aux)
                aux_ctrl <= wr_data & AUX_CTRL_MASK;
            if (wr_int)
                int_en <= wr_data & INT_EN_MASK;
            if (wr_dp)
                dp_ctrl <= wr_data & DP_CTRL_MASK;
            else if (strap_load)
            begin
                dp_ctrl[DP_NRZI] <= straps[3];
                dp_ctrl[DP_4B5B] <= straps[2];
                dp_ctrl[DP_MLT3_DIS] <= straps[1];
                dp_ctrl[DP_SCR_DIS] <= straps[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Latched status events
    // ------------------------------------------------------------
    logic [NUM_EVENTS-1:0] flags;
    logic overrun;
    logic link_q;
    logic an_q;
    logic err_full;
    logic [NUM_EVENTS-1:0] events;

    pasic_err_counter #(.WIDTH(ERR_CNT_W)) u_err_cnt (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_count(i_rx_error),
        .i_enable(!dp_ctrl[DP_ERR_CNT_DIS]),
        .o_wrap(err_full)
    );

    assign events[EV_ERR_FULL] = err_full;
    assign events[EV_PAGE] = i_page_rx;
    assign events[EV_PAR_FAULT] = i_par_det_fault;
    assign events[EV_CODE_WORD] = i_code_word_rx;
    assign events[EV_LINK_DOWN] = link_q && !i_link_up;
    assign events[EV_REM_FAULT] = i_remote_fault;
    assign events[EV_AN_DONE] = i_an_complete && !an_q;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            flags <= '0;
            overrun <= 1'b0;
            link_q <= 1'b0;
            an_q <= 1'b0;
        end
        else
        begin
            link_q <= i_link_up;
            an_q <= i_an_complete;
            flags <= latch_next(flags, events, rd_stat);
            overrun <= i_fifo_overrun || (overrun && !rd_stat);
        end
    end

    // ------------------------------------------------------------
    // Read data and outputs
    // ------------------------------------------------------------
    wire addr_iso = (phy_addr == PHY_ADDR_ISOLATE) && (strap_cnt > STRAP_WAIT);
    wire iso = dp_ctrl[DP_ISOLATE] || addr_iso;
    wire [2:0] live_mode = {i_full_duplex, i_speed_100, !i_speed_100};
    wire [2:0] mode = (iso && !i_an_enable) ? MODE_ISOLATED :
                      (i_an_enable && !i_an_complete) ? MODE_NEGOTIATING :
                      live_mode;
    wire [15:0] stat_rd = {4'h0, overrun, 1'b0, i_speed_100, i_full_duplex,
                           i_pause_en, flags};
    wire [15:0] dp_rd = {dp_ctrl[15:13], i_an_complete,
                         dp_ctrl[11:5], mode, dp_ctrl[1:0]};

    assign rdata = (hdr_reg == REG_AUX_CTRL) ? aux_ctrl :
                   (hdr_reg == REG_AUX_STAT) ? stat_rd :
                   (hdr_reg == REG_INT_EN) ? int_en :
                   (hdr_reg == REG_DP_CTRL) ? dp_rd : 16'h0000;

    assign o_bypass_align = aux_ctrl[AUX_BYPASS_ALIGN];
    assign o_raw_5b_rx = aux_ctrl[AUX_BYPASS_ALIGN] && !dp_ctrl[DP_4B5B];
    assign o_err_cnt_disable = dp_ctrl[DP_ERR_CNT_DIS];
    assign o_rx_vpp_sel = dp_ctrl[DP_RX_VPP];
    assign o_remote_loopback = dp_ctrl[DP_LOOPBACK];
    assign o_dc_restore_en = dp_ctrl[DP_DC_RESTORE];
    assign o_nrzi_en = dp_ctrl[DP_NRZI];
    assign o_4b5b_en = dp_ctrl[DP_4B5B];
    assign o_isolate = iso;
    assign o_mode = mode;
    assign o_mlt3_disable = dp_ctrl[DP_MLT3_DIS];
    assign o_scrambler_disable = dp_ctrl[DP_SCR_DIS];
    assign o_irq = |(flags & int_en[NUM_EVENTS-1:0]);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    a_bypass_write: assert property (wr_aux |=> o_bypass_align == $past(wr_data[7]))
        else $error("alignment bypass did not follow write");
    a_raw_codes: assert property (o_bypass_align && !o_4b5b_en |-> o_raw_5b_rx)
        else $error("raw code path not selected");
    a_overrun_hold: assert property (overrun && !rd_stat |=> overrun)
        else $error("overrun flag dropped without read");
    a_read_clears: assert property (rd_stat && !(|events) |=> flags == '0)
        else $error("status read did not clear flags");
    a_link_down: assert property ($fell(i_link_up) |=> flags[EV_LINK_DOWN])
        else $error("link down not latched");
    a_page_flag: assert property (i_page_rx |=> flags[EV_PAGE] [*1])
        else $error("page received not latched");
    a_counter_stop: assert property (o_err_cnt_disable |=> !err_full)
        else $error("error counter wrapped while disabled");
    a_loop_write: assert property (wr_dp |=> o_remote_loopback == $past(wr_data[9]))
        else $error("loopback did not follow write");
    a_mode_iso: assert property (o_isolate && !i_an_enable |-> o_mode == 3'h7)
        else $error("isolated mode code wrong");
    a_irq_drop: assert property (rd_stat && !(|events) |=> !o_irq)
        else $error("interrupt held after status read");

    c_status_read: cover property (rd_stat && o_irq);
    c_write_dp: cover property (wr_dp);
    c_mdio_drive: cover property (o_mdio_oe [*8]);

endmodule

// ### bench/pasic_mdio_master.sv
// Station management master model that sends MDIO frames on MDC and MDIO.
// Assumes the bench resolves the shared MDIO line with a pull-up.
`timescale 1ns/1ps
module pasic_mdio_master
    import pasic_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_mdio,
    output logic o_mdc,
    output logic o_mdio_out,
    output logic o_mdio_oe
);
    initial
    begin
        o_mdc = 1'b0;
        o_mdio_out = 1'b1;
        o_mdio_oe = 1'b0;
    end

    // MDC runs only inside frames, at an eighth of i_clk, and rests low between them.
    task automatic tick(input logic oe, input logic b, output logic s);
        o_mdio_oe <= oe;
        o_mdio_out <= b;
        repeat (4) @(posedge i_clk);
        o_mdc <= 1'b1;
        s = i_mdio;
        repeat (4) @(posedge i_clk);
        o_mdc <= 1'b0;
    endtask

    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
        input logic [15:0] wd, output logic [15:0] rd);
        logic [33:0] f;
        logic [15:0] w;
        logic s;
        w = (rg == REG_AUX_CTRL) ? (wd & AUX_CTRL_MASK) : wd;
        f = {4'b1101, op, phy, rg, 2'b10, w};
        rd = 16'h0000;
        for (int i = 33; i >= 0; i--)
        begin
            tick((op == OP_WRITE) || (i > 17), f[i], s);
            if (i < 16)
                rd[i] = s;
        end
        tick(1'b0, 1'b1, s);
    endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench for the PHY management registers, reached over MDIO.
// Assumes the MDIO master model beside it and a pull-up on the MDIO line.
`timescale 1ns/1ps
module testbench
    import pasic_pkg::*;
;
    localparam logic [4:0] PHY = 5'h01;
    logic i_clk, i_reset_n, link_up, an_en, an_cmp, pause, spd, fdx;
    logic mdc, mac_out, mac_oe, dut_out, dut_oe, bypass, raw5b, irq;
    logic [11:0] ev;
    logic [8:0] dp_pins;
    logic [2:0] mode;
    logic [4:0] strap_addr;
    logic [15:0] d, e;
    wire logic mdio;
    int fails = 0;
    int samples_checked = 0;
    int evl [7] = '{1, 2, 3, 4, 5, 6, 11};

    assign mdio = dut_oe ? dut_out : (mac_oe ? mac_out : 1'b1);

    pasic_mdio_master u_mac (.i_clk(i_clk), .i_mdio(mdio), .o_mdc(mdc),
        .o_mdio_out(mac_out), .o_mdio_oe(mac_oe));

    pasic_regs u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_mdc(mdc), .i_mdio(mdio),
        .o_mdio_out(dut_out), .o_mdio_oe(dut_oe), .i_strap_phy_addr(strap_addr),
        .i_strap_nrzi_en(1'b1), .i_strap_4b5b_en(1'b1), .i_strap_mlt3_dis(1'b0),
        .i_strap_scr_dis(1'b1), .i_fifo_overrun(ev[11]), .i_remote_fault(ev[5]),
        .i_link_up(link_up), .i_code_word_rx(ev[3]), .i_par_det_fault(ev[2]),
        .i_page_rx(ev[1]), .i_rx_error(ev[0]), .i_an_enable(an_en),
        .i_an_complete(an_cmp), .i_pause_en(pause), .i_speed_100(spd),
        .i_full_duplex(fdx), .o_bypass_align(bypass), .o_raw_5b_rx(raw5b),
        .o_err_cnt_disable(dp_pins[8]), .o_rx_vpp_sel(dp_pins[7]),
        .o_remote_loopback(dp_pins[6]), .o_dc_restore_en(dp_pins[5]),
        .o_nrzi_en(dp_pins[4]), .o_4b5b_en(dp_pins[3]), .o_isolate(dp_pins[2]),
        .o_mode(mode), .o_mlt3_disable(dp_pins[1]), .o_scrambler_disable(dp_pins[0]),
        .o_irq(irq));

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
            fails++;
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        logic [15:0] r;
        u_mac.frame(OP_WRITE, PHY, a, v, r);
    endtask

    task automatic rc(input string n, input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] r;
        u_mac.frame(OP_READ, PHY, a, 16'h0000, r);
        chk(n, r, exp);
    endtask

    task automatic fire(input int i);
        @(posedge i_clk);
        if (i == 4)
            link_up <= 1'b0;
        else if (i == 6)
            an_cmp <= 1'b1;
        else
            ev[i] <= 1'b1;
        @(posedge i_clk);
        ev <= 12'h000;
        repeat (2) @(posedge i_clk);
    endtask

    // Error pulses are held as a level, so each sampled cycle counts once.
    task automatic cnt(input int n);
        @(posedge i_clk);
        ev[0] <= 1'b1;
        repeat (n) @(posedge i_clk);
        ev[0] <= 1'b0;
    endtask

    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    initial
    begin
        #9000000;
        fails++;
        final_report();
    end

    initial
    begin
        i_reset_n = 1'b0;
        ev = 12'h000;
        {link_up, an_en, an_cmp, pause, spd, fdx} = 6'b110000;
        strap_addr = PHY;
        repeat (16) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (8) @(posedge i_clk);
        rc("aux_rst", REG_AUX_CTRL, 16'h0000);
        rc("stat_rst", REG_AUX_STAT, 16'h0000);
        rc("inten_rst", REG_INT_EN, 16'h0000);
        rc("dp_rst", REG_DP_CTRL, 16'h01c1);
        rc("unmapped", 5'h14, 16'hffff);
        u_mac.frame(OP_READ, 5'h02, REG_INT_EN, 16'h0000, d);
        chk("other_phy", d, 16'hffff);
        cnt(65000);
        wr(REG_DP_CTRL, 16'h2100);
        cnt(600);
        rc("cnt_off", REG_AUX_STAT, 16'h0000);
        wr(REG_DP_CTRL, 16'h0100);
        cnt(535);
        rc("cnt_short", REG_AUX_STAT, 16'h0000);
        cnt(1);
        rc("cnt_full", REG_AUX_STAT, 16'h0001);
        rc("cnt_clr", REG_AUX_STAT, 16'h0000);
        @(posedge i_clk);
        {pause, spd, fdx} <= 3'b111;
        rc("stat_live", REG_AUX_STAT, 16'h0380);
        wr(REG_INT_EN, 16'hffff);
        rc("inten_mask", REG_INT_EN, 16'h007f);
        foreach (evl[k])
        begin
            e = 16'h0001 << evl[k];
            wr(REG_INT_EN, INT_EN_MASK & ~e);
            fire(evl[k]);
            chk("irq_masked", 16'(irq), 16'h0000);
            wr(REG_INT_EN, INT_EN_MASK & e);
            chk("irq_set", 16'(irq), 16'(evl[k] < 7));
            rc("stat_set", REG_AUX_STAT, 16'h0380 | e);
            chk("irq_clr", 16'(irq), 16'h0000);
            rc("stat_clr", REG_AUX_STAT, 16'h0380);
        end
        wr(REG_AUX_CTRL, 16'h00a6);
        chk("bypass", 16'(bypass), 16'h0001);
        chk("raw5b_on", 16'(raw5b), 16'h0001);
        u_mac.frame(OP_READ, PHY, REG_AUX_CTRL, 16'h0000, d);
        chk("aux_rd", d & AUX_CTRL_MASK, 16'h00a6);
        wr(REG_DP_CTRL, 16'h0140);
        chk("raw5b_off", 16'(raw5b), 16'h0000);
        wr(REG_DP_CTRL, 16'hffff);
        rc("dp_all", REG_DP_CTRL, 16'h3bfb);
        chk("dp_pins", 16'(dp_pins), 16'h01ff);
        @(posedge i_clk);
        an_en <= 1'b0;
        @(posedge i_clk);
        @(posedge i_clk);
        chk("mode_iso", 16'(mode), 16'h0007);
        wr(REG_DP_CTRL, 16'h0000);
        for (int m = 0; m < 4; m++)
        begin
            {fdx, spd} <= m[1:0];
            @(posedge i_clk);
            @(posedge i_clk);
            chk("mode", 16'(mode), 16'({m[1], m[0], ~m[0]}));
        end
        {an_en, an_cmp} <= 2'b10;
        @(posedge i_clk);
        @(posedge i_clk);
        chk("mode_neg", 16'(mode), 16'h0000);
        // A second reset with address zero strapped must isolate without bit 5.
        i_reset_n <= 1'b0;
        strap_addr <= 5'h00;
        repeat (4) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (8) @(posedge i_clk);
        chk("addr_iso", 16'(dp_pins[2]), 16'h0001);
        u_mac.frame(OP_READ, 5'h00, REG_DP_CTRL, 16'h0000, d);
        chk("dp_rst2", d, 16'h01c1);
        an_en <= 1'b0;
        @(posedge i_clk);
        @(posedge i_clk);
        chk("mode_iso2", 16'(mode), 16'h0007);
        final_report();
    end
endmodule
